// ==== core/fhs_seek_ctrl.sv ====
// Purpose: Head positioning, Read ID and interrupt cause logic of a disk controller.
// Assumes: Classic Wishbone master; id and transfer strobes come from same-clock logic.
// Notes: Drive pins track_zero_in and index_pulse_in are synchronised here.
`timescale 1ns/1ns
module fhs_seek_ctrl
   import fhs_pkg::*;
#(
   parameter int MS_CYC_P = MS_CYC
)
(
   input logic ref_clk,
   input logic nrst,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input logic index_pulse_in,
   input logic [NUM_DRIVES-1:0] track_zero_in,
   input logic id_valid_in,
   input fhs_id_s id_fields_in,
   input logic xfer_result_in,
   input logic byte_req_in,
   output logic [NUM_DRIVES-1:0] step_out,
   output logic [NUM_DRIVES-1:0] dir_out,
   output logic controller_irq
);
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RDID = 2'b01
   } fhs_state_e;

   fhs_state_e state_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic idx_prev_q;
   logic [1:0] idx_cnt_q;
   logic [19:0] ms_cnt_q;
   logic [3:0] srt_q;
   logic [7:0] cfg_q;
   logic cmd_busy_q;
   logic pd_q;
   logic init_q;
   logic poll_pend_q;
   logic irq_q;
   logic xfer_irq_q;
   logic [NUM_DRIVES-1:0] pend_q;
   logic [NUM_DRIVES-1:0] bad_q;
   fhs_st0_s res_st0_q;
   logic [7:0] res_pcn_q;
   logic res_ma_q;
   fhs_id_s id_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic bus_req;
   logic wr_en;
   logic cmd_wr;
   logic cfg_wr;
   logic [31:0] rdata;
   fhs_op_e op;
   logic [1:0] drv;
   logic [7:0] arg;
   logic accept;
   logic is_move;
   logic move_ok;
   logic sense_acc;
   logic pwr_up;
   logic rdid_go;
   logic busy;
   logic [NUM_DRIVES-1:0] moving;
   logic [NUM_DRIVES-1:0] mv_done;
   logic [NUM_DRIVES-1:0] mv_fault;
   logic [NUM_DRIVES-1:0] drive_busy;
   logic [7:0] pcn_w [NUM_DRIVES];
   logic [4:0] interval;
   logic tick_ms;
   logic idx_rise;
   logic rdid_hit;
   logic rdid_miss;
   logic [1:0] sense_drv;
   logic [NUM_DRIVES-1:0] pend_clr;
   logic [NUM_DRIVES-1:0] pend_rest;
   logic ev_set;
   fhs_move_e mv_mode;

   assign bus_req = wb_cyc_i && wb_stb_i;
   // Writes act on the edge where the master sees ack, as it holds the request until then.
   assign wr_en = bus_req && wb_we_i && ack_q;
   assign cmd_wr = wr_en && wb_adr_i == ADDR_CMD && (&wb_sel_i[1:0]);
   assign cfg_wr = wr_en && wb_adr_i == ADDR_CONFIG && wb_sel_i[0];
   assign op = fhs_op_e'(wb_dat_i[CMD_OP_LSB +: 4]);
   assign drv = wb_dat_i[CMD_DRV_LSB +: 2];
   assign arg = wb_dat_i[CMD_ARG_LSB +: 8];

   // While powered down only the wake command is taken; Read ID blocks others.
   assign accept = cmd_wr && (pd_q ? op == OP_PWR_UP : state_q == ST_IDLE);
   assign is_move = op == OP_SEEK || op == OP_RECAL || op == OP_REL_SEEK;
   assign move_ok = accept && is_move && !drive_busy[drv];
   assign sense_acc = accept && op == OP_SENSE_INT;
   assign pwr_up = accept && op == OP_PWR_UP;
   assign rdid_go = accept && op == OP_READ_ID;
   assign mv_mode = op == OP_RECAL ? MV_RECAL : (op == OP_REL_SEEK ? MV_REL : MV_SEEK);

   // Positioning commands release busy after their command cycle.
   assign busy = cmd_busy_q || state_q != ST_IDLE;
   // The done pulse counts too, so a drive never looks free just before it turns pending.
   assign drive_busy = moving | mv_done | pend_q;

   assign rdata = wb_adr_i == ADDR_STATUS ? {25'h0, irq_q, pd_q, drive_busy, busy} :
                  wb_adr_i == ADDR_RESULT ? {15'h0, res_ma_q, res_pcn_q, res_st0_q} :
                  wb_adr_i == ADDR_IDFIELD ? id_q :
                  wb_adr_i == ADDR_CONFIG ? {20'h0, srt_q, cfg_q} :
                  32'h0;

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end
      else
      begin
         ack_q <= bus_req && !ack_q;
         if (bus_req && !ack_q)
            dat_q <= rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and timing enables.
   assign idx_rise = sync_q[4] && !idx_prev_q;
   assign tick_ms = ms_cnt_q == 20'(MS_CYC_P - 1);
   assign interval = SRT_BASE - {1'b0, srt_q};

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= 5'h00;
         sync_q <= 5'h00;
         idx_prev_q <= 1'b0;
         ms_cnt_q <= 20'h0;
      end
      else
      begin
         meta_q <= {index_pulse_in, track_zero_in};
         sync_q <= meta_q;
         idx_prev_q <= sync_q[4];
         ms_cnt_q <= tick_ms ? 20'h0 : ms_cnt_q + 20'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One positioner per drive so overlapped seeks keep separate cylinders.
   for (genvar d = 0; d < NUM_DRIVES; d++)
   begin : g_drive
      fhs_positioner u_pos
      (
         .ref_clk(ref_clk),
         .nrst(nrst),
         .clear(pwr_up),
         .start(move_ok && drv == 2'(d)),
         .mode_in(mv_mode),
         .rel_dir(wb_dat_i[CMD_DIR_BIT]),
         .arg(arg),
         .interval(interval),
         .tick_ms(tick_ms),
         .trk0(sync_q[d]),
         .step_q(step_out[d]),
         .dir_q(dir_out[d]),
         .pcn_q(pcn_w[d]),
         .done_q(mv_done[d]),
         .fault_q(mv_fault[d]),
         .moving(moving[d])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read ID sequencing.
   assign rdid_hit = state_q == ST_RDID && id_valid_in;
   assign rdid_miss = state_q == ST_RDID && !id_valid_in && idx_rise && idx_cnt_q == 2'h1;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         idx_cnt_q <= 2'h0;
         id_q <= '0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (rdid_go)
               begin
                  idx_cnt_q <= 2'h0;
                  state_q <= ST_RDID;
               end
            ST_RDID:
               if (rdid_hit)
               begin
                  id_q <= id_fields_in;
                  state_q <= ST_IDLE;
               end
               else if (rdid_miss)
                  state_q <= ST_IDLE;
               else if (idx_rise)
                  idx_cnt_q <= idx_cnt_q + 2'h1;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt causes and the sense result.
   assign sense_drv = pend_q[0] ? 2'h0 : pend_q[1] ? 2'h1 : pend_q[2] ? 2'h2 : 2'h3;
   assign pend_clr = (sense_acc && !poll_pend_q && |pend_q) ? 4'(1 << sense_drv) : 4'h0;
   assign pend_rest = pend_q & ~pend_clr;

   // Read ID, the positioning ends, xfer_result_in and the reset poll raise the line; other commands never do.
   assign ev_set = (|mv_done) || rdid_hit || rdid_miss || xfer_result_in ||
                   (!init_q && !cfg_q[CFG_POLL_DIS_BIT]);

   assign controller_irq = irq_q || xfer_irq_q;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         init_q <= 1'b0;
         poll_pend_q <= 1'b0;
         irq_q <= 1'b0;
         xfer_irq_q <= 1'b0;
         pend_q <= 4'h0;
         bad_q <= 4'h0;
         res_st0_q <= '0;
         res_pcn_q <= 8'h00;
         res_ma_q <= 1'b0;
      end
      else if (pwr_up)
      begin
         pend_q <= 4'h0;
         bad_q <= 4'h0;
         poll_pend_q <= 1'b0;
         irq_q <= 1'b0;
         res_st0_q <= '0;
         res_pcn_q <= 8'h00;
         res_ma_q <= 1'b0;
      end
      else
      begin
         init_q <= 1'b1;
         xfer_irq_q <= cfg_q[CFG_NDMA_BIT] && byte_req_in;
         // A new cause in the sense cycle still wins over the clear.
         irq_q <= ev_set || (sense_acc ? |pend_rest : irq_q);
         if (!init_q && !cfg_q[CFG_POLL_DIS_BIT])
            poll_pend_q <= 1'b1;
         else if (sense_acc)
            poll_pend_q <= 1'b0;
         pend_q <= pend_rest | mv_done;
         bad_q <= (bad_q & ~pend_clr & ~mv_done) | (mv_done & mv_fault);
         if (sense_acc)
         begin
            res_ma_q <= 1'b0;
            if (poll_pend_q)
            begin
               res_st0_q <= '{ic: IC_POLL, se: 1'b0, ec: 1'b0, nr: 1'b0,
                              hd: 1'b0, ds: 2'h0};
            end
            else if (|pend_q)
            begin
               res_st0_q <= '{ic: bad_q[sense_drv] ? IC_ABNORMAL : IC_NORMAL,
                              se: 1'b1, ec: bad_q[sense_drv], nr: 1'b0,
                              hd: 1'b0, ds: sense_drv};
               res_pcn_q <= pcn_w[sense_drv];
            end
            else
            begin
               res_st0_q <= '{ic: IC_INVALID, se: 1'b0, ec: 1'b0, nr: 1'b0,
                              hd: 1'b0, ds: 2'h0};
            end
         end
         else if (rdid_hit || rdid_miss)
         begin
            res_st0_q <= '{ic: rdid_miss ? IC_ABNORMAL : IC_NORMAL,
                           se: 1'b0, ec: 1'b0, nr: 1'b0, hd: 1'b0, ds: 2'h0};
            res_ma_q <= rdid_miss;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software settings.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         srt_q <= SRT_RST;
         cfg_q <= CFG_RST;
         cmd_busy_q <= 1'b0;
         pd_q <= 1'b0;
      end
      else
      begin
         cmd_busy_q <= accept;
         if (accept && op == OP_SPECIFY)
            srt_q <= arg[3:0];
         if (cfg_wr)
            cfg_q <= wb_dat_i[7:0];
         if (accept && op == OP_PWR_DOWN)
            pd_q <= 1'b1;
         else if (pwr_up)
            pd_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_cmd_phase;
      cmd_busy_q;
   endsequence
   sequence s_exec_free;
      !busy;
   endsequence

   a_move_not_busy: assert property (move_ok |=> s_cmd_phase ##1 s_exec_free)
      else $error("busy held in positioning execution");
   a_sense_head: assert property (sense_acc |=> !res_st0_q.hd)
      else $error("head bit not zero");
   a_sense_drop: assert property (sense_acc && !ev_set && pend_rest == 4'h0 |=> !irq_q)
      else $error("sense did not drop interrupt");
   a_move_irq: assert property (|mv_done |=> irq_q && |drive_busy)
      else $error("positioning end without interrupt");
   a_rdid_miss: assert property (rdid_miss |=> res_st0_q.ic == IC_ABNORMAL && res_ma_q
      && state_q == ST_IDLE) else $error("missing mark not reported");
   a_rdid_take: assert property (rdid_hit |=> id_q == $past(id_fields_in) && irq_q)
      else $error("id field not captured");
   a_poll_cause: assert property (sense_acc && poll_pend_q |=> res_st0_q.ic == IC_POLL
      && !res_st0_q.se) else $error("poll cause wrong");
   a_quiet_cmd: assert property (accept && op == OP_SPECIFY && !irq_q && !ev_set
      |=> !irq_q) else $error("specify raised interrupt");
   a_wake_clear: assert property (pwr_up |=> pend_q == 4'h0 && pcn_w[0] == 8'h00)
      else $error("wake left status");
endmodule : fhs_seek_ctrl

// ==== core/fhs_pkg.sv ====
// Purpose: Shared constants and types for the floppy head seek control block.
// Assumes: 100 MHz ref_clk, classic Wishbone register access.
// Notes: Offsets are byte addresses of 32-bit words.
package fhs_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_PULSE_NS = 1000;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int NUM_DRIVES = 4;
   localparam logic [7:0] RECAL_MAX_STEPS = 8'h4f;
   localparam logic [4:0] SRT_BASE = 5'h10;
   localparam logic [3:0] SRT_RST = 4'h0;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam logic [7:0] ADDR_IDFIELD = 8'h0c;
   localparam logic [7:0] ADDR_CONFIG = 8'h10;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DRV_LSB = 4;
   localparam int CMD_DIR_BIT = 6;
   localparam int CMD_ARG_LSB = 8;
   localparam int CFG_POLL_DIS_BIT = 0;
   localparam int CFG_NDMA_BIT = 1;
   localparam logic [1:0] IC_NORMAL = 2'h0;
   localparam logic [1:0] IC_ABNORMAL = 2'h1;
   localparam logic [1:0] IC_INVALID = 2'h2;
   localparam logic [1:0] IC_POLL = 2'h3;

   typedef enum logic [3:0]
   {
      OP_SPECIFY = 4'h0,
      OP_SEEK = 4'h1,
      OP_RECAL = 4'h2,
      OP_REL_SEEK = 4'h3,
      OP_READ_ID = 4'h4,
      OP_SENSE_INT = 4'h5,
      OP_PWR_DOWN = 4'h6,
      OP_PWR_UP = 4'h7,
      OP_OTHER = 4'h8
   } fhs_op_e;

   typedef enum logic [1:0]
   {
      MV_SEEK = 2'h0,
      MV_RECAL = 2'h1,
      MV_REL = 2'h2
   } fhs_move_e;

   typedef struct packed
   {
      logic [1:0] ic;
      logic se;
      logic ec;
      logic nr;
      logic hd;
      logic [1:0] ds;
   } fhs_st0_s;

   typedef struct packed
   {
      logic [7:0] c;
      logic [7:0] h;
      logic [7:0] r;
      logic [7:0] n;
   } fhs_id_s;
endpackage : fhs_pkg

// ==== core/fhs_positioner.sv ====
// Purpose: One drive's head positioner: step and direction sequencing.
// Assumes: trk0 is already synchronised; tick_ms is a one-cycle enable.
// Notes: Any step gap may be up to one ms tick shorter than the interval.
`timescale 1ns/1ns
module fhs_positioner
   import fhs_pkg::*;
(
   input logic ref_clk,
   input logic nrst,
   input logic clear,
   input logic start,
   input fhs_move_e mode_in,
   input logic rel_dir,
   input logic [7:0] arg,
   input logic [4:0] interval,
   input logic tick_ms,
   input logic trk0,
   output logic step_q,
   output logic dir_q,
   output logic [7:0] pcn_q,
   output logic done_q,
   output logic fault_q,
   output logic moving
);
   typedef enum logic [2:0]
   {
      P_IDLE = 3'b000,
      P_CHK = 3'b001,
      P_STEP = 3'b011,
      P_GAP = 3'b010
   } fhs_pstate_e;

   fhs_pstate_e state_q;
   fhs_move_e mode_q;
   logic [7:0] tgt_q;
   logic [7:0] cnt_q;
   logic [6:0] tmr_q;
   logic finish_w;
   logic fault_w;
   logic pulse_end;

   assign finish_w = (mode_q == MV_SEEK && pcn_q == tgt_q) ||
                     (mode_q == MV_RECAL && (trk0 || cnt_q == RECAL_MAX_STEPS)) ||
                     (mode_q == MV_REL && (cnt_q == tgt_q || (!dir_q && trk0)));
   assign fault_w = (mode_q == MV_RECAL && !trk0) || (mode_q == MV_REL && cnt_q != tgt_q);
   assign pulse_end = tmr_q == 7'(STEP_PULSE_CYC - 1);
   assign moving = state_q != P_IDLE;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= P_IDLE;
         mode_q <= MV_SEEK;
         tgt_q <= 8'h00;
         cnt_q <= 8'h00;
         tmr_q <= 7'h00;
         pcn_q <= 8'h00;
         step_q <= 1'b0;
         dir_q <= 1'b0;
         done_q <= 1'b0;
         fault_q <= 1'b0;
      end
      else if (clear)
      begin
         state_q <= P_IDLE;
         pcn_q <= 8'h00;
         step_q <= 1'b0;
         done_q <= 1'b0;
         fault_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            P_IDLE:
               if (start)
               begin
                  mode_q <= mode_in;
                  tgt_q <= arg;
                  cnt_q <= 8'h00;
                  fault_q <= 1'b0;
                  dir_q <= (mode_in == MV_REL) ? rel_dir : 1'b0;
                  if (mode_in == MV_RECAL)
                     pcn_q <= 8'h00;
                  state_q <= P_CHK;
               end
            P_CHK:
               if (finish_w)
               begin
                  done_q <= 1'b1;
                  fault_q <= fault_w;
                  state_q <= P_IDLE;
               end
               else
               begin
                  if (mode_q == MV_SEEK)
                     dir_q <= pcn_q < tgt_q;
                  step_q <= 1'b1;
                  tmr_q <= 7'h00;
                  state_q <= P_STEP;
               end
            P_STEP:
               if (pulse_end)
               begin
                  step_q <= 1'b0;
                  tmr_q <= 7'h00;
                  cnt_q <= cnt_q + 8'h01;
                  if (mode_q != MV_RECAL)
                     pcn_q <= dir_q ? pcn_q + 8'h01 : pcn_q - 8'h01;
                  state_q <= P_GAP;
               end
               else
                  tmr_q <= tmr_q + 7'h01;
            P_GAP:
               if (tick_ms)
               begin
                  // Gap counted in whole ms ticks from the step interval.
                  if (tmr_q + 7'h01 >= {2'b00, interval})
                     state_q <= P_CHK;
                  tmr_q <= tmr_q + 7'h01;
               end
            default:
               state_q <= P_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst || clear);

   a_recal_zero_pcn: assert property (state_q == P_IDLE && start && mode_in == MV_RECAL
      |=> pcn_q == 8'h00) else $error("recalibrate did not zero cylinder");
   a_recal_dir_out: assert property (moving && mode_q == MV_RECAL |-> !dir_q)
      else $error("recalibrate stepping inward");
   a_recal_found: assert property (state_q == P_CHK && mode_q == MV_RECAL && trk0
      |=> done_q && !fault_q && !step_q) else $error("track zero not ending");
   a_recal_limit: assert property (state_q == P_CHK && mode_q == MV_RECAL && !trk0
      && cnt_q == 8'h4f |=> done_q && fault_q) else $error("step limit missed");
   a_seek_inward: assert property (state_q == P_CHK && mode_q == MV_SEEK && pcn_q < tgt_q
      |=> dir_q && step_q) else $error("seek inward wrong");
   a_seek_match: assert property (state_q == P_CHK && mode_q == MV_SEEK && pcn_q == tgt_q
      |=> done_q && !step_q ##1 !moving) else $error("seek match missed");
endmodule : fhs_positioner

// ==== tb/fhs_drive_model.sv ====
// Purpose: Behavioural mechanism of four drives: head position and track zero.
// Assumes: One track per rising edge of step_out; dir 1 moves the head inward.
// Notes: Stepping outward at track 0 does nothing, as the mechanical stop would.
`timescale 1ns/1ns
module fhs_drive_model
   import fhs_pkg::*;
(
   input logic ref_clk,
   input logic [NUM_DRIVES-1:0] step_out,
   input logic [NUM_DRIVES-1:0] dir_out,
   output logic [NUM_DRIVES-1:0] track_zero_in
);
   int trk [NUM_DRIVES] = '{3, 100, 0, 0};
   int cnt = 0;
   int rise0 = 0;
   int gap = 0;
   logic [NUM_DRIVES-1:0] step_q = '0;
   logic [NUM_DRIVES-1:0] last_dir = '0;
   always_comb
   begin
      for (int i = 0; i < NUM_DRIVES; i++)
         track_zero_in[i] = (trk[i] == 0);
   end
   always @(posedge ref_clk)
   begin
      cnt <= cnt + 1;
      step_q <= step_out;
      for (int i = 0; i < NUM_DRIVES; i++)
      begin
         if (step_out[i] && !step_q[i])
         begin
            last_dir[i] <= dir_out[i];
            if (dir_out[i])
               trk[i] <= trk[i] + 1;
            else if (trk[i] > 0)
               trk[i] <= trk[i] - 1;
         end
      end
      if (step_out[0] && !step_q[0])
      begin
         gap <= cnt - rise0;
         rise0 <= cnt;
      end
   end
endmodule : fhs_drive_model

// ==== tb/fhs_seek_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the head seek control block.
// Assumes: Commands are spaced by the bus tasks; the drive model answers the pins.
// Notes: MS_CYC_P is shortened so the 79-step recalibrate stays quick.
`timescale 1ns/1ns
module fhs_seek_ctrl_tb_top;
   import fhs_pkg::*;
   typedef struct {logic [7:0] tgt; logic dir;} fhs_row_s;
   logic ref_clk, nrst, cyc, stb, we, ack, index_pulse_in, id_valid_in, xfer, breq, irq;
   logic [7:0] adr;
   logic [3:0] sel, step_out, dir_out, trk0;
   logic [31:0] wdat, rdat, r;
   fhs_id_s id_f;
   int errors = 0;
   int comparisons = 0;
   fhs_row_s rows [4] = '{'{8'h05, 1'b1}, '{8'h02, 1'b0}, '{8'h02, 1'b0}, '{8'h07, 1'b1}};
   fhs_seek_ctrl #(.MS_CYC_P(20)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .index_pulse_in(index_pulse_in),
      .track_zero_in(trk0), .id_valid_in(id_valid_in), .id_fields_in(id_f),
      .xfer_result_in(xfer), .byte_req_in(breq), .step_out(step_out), .dir_out(dir_out),
      .controller_irq(irq));
   fhs_drive_model drv_u (.ref_clk(ref_clk), .step_out(step_out), .dir_out(dir_out),
      .track_zero_in(trk0));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rd);
      @(posedge ref_clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
      do
         @(posedge ref_clk);
      while (ack !== 1'b1);
      rd = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask : wb
   task automatic cmd(input logic [3:0] op, input logic [1:0] drv, input logic [7:0] arg);
      logic [31:0] d;
      wb(1'b1, ADDR_CMD, {16'h0000, arg, 2'b00, drv, op}, 4'hf, d);
   endtask : cmd
   task automatic sense(output logic [31:0] rd);
      cmd(OP_SENSE_INT, 2'h0, 8'h00);
      wb(1'b0, ADDR_RESULT, 32'h0, 4'hf, rd);
   endtask : sense
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 30000)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk("irq_raised", 1, irq);
   endtask : wait_irq
   function automatic logic [31:0] res(input logic [1:0] ic, input logic se, input logic ec,
      input logic [1:0] ds, input logic [7:0] present_cylinder);
      return {16'h0000, present_cylinder, ic, se, ec, 2'b00, ds};
   endfunction : res
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (80000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end
   initial
   begin
      {nrst, cyc, stb, we, adr, sel, wdat, index_pulse_in, id_valid_in, id_f, xfer, breq} = '0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("poll_irq", 1, irq);
      sense(r);
      chk("poll_cause", res(IC_POLL, 0, 0, 0, 0), r & 32'h100ff);
      chk("irq_clear", 0, irq);
      cmd(OP_SPECIFY, 2'h0, 8'h0e);
      cmd(OP_RECAL, 2'h0, 8'h00);
      wait_irq();
      sense(r);
      chk("recal", res(IC_NORMAL, 1, 0, 0, 0), r);
      chk("recal_trk", 0, drv_u.trk[0]);
      $display("test reset and recalibrate done");
      foreach (rows[i])
      begin
         cmd(OP_SEEK, 2'h0, rows[i].tgt);
         wb(1'b0, ADDR_STATUS, 32'h0, 4'hf, r);
         chk("busy", 32'h2, r & 32'h3);
         wait_irq();
         sense(r);
         chk("seek", res(IC_NORMAL, 1, 0, 0, rows[i].tgt), r);
         chk("seek_dir", rows[i].dir, drv_u.last_dir[0]);
         chk("seek_trk", rows[i].tgt, drv_u.trk[0]);
      end
      chk("step_gap", 1, drv_u.gap >= 120 && drv_u.gap <= 150);
      $display("test seek table done");
      cmd(OP_RECAL, 2'h1, 8'h00);
      cmd(OP_SEEK, 2'h2, 8'h01);
      wait_irq();
      sense(r);
      chk("overlap", res(IC_NORMAL, 1, 0, 2, 1), r);
      wait_irq();
      sense(r);
      chk("recal_fail", res(IC_ABNORMAL, 1, 1, 1, 0), r & 32'h100ff);
      chk("recal_steps", 21, drv_u.trk[1]);
      wb(1'b1, ADDR_CMD, {16'h0000, 8'h02, 2'b01, 2'h3, OP_REL_SEEK}, 4'hf, r);
      wait_irq();
      sense(r);
      chk("rel_in", res(IC_NORMAL, 1, 0, 3, 2), r);
      wb(1'b1, ADDR_CMD, {16'h0000, 8'h03, 2'b00, 2'h3, OP_REL_SEEK}, 4'hf, r);
      wait_irq();
      sense(r);
      chk("rel_out_stop", res(IC_ABNORMAL, 1, 1, 3, 0), r);
      $display("test overlap and recalibrate limit done");
      cmd(OP_READ_ID, 2'h0, 8'h00);
      repeat (2)
      begin
         repeat (10) @(posedge ref_clk);
         index_pulse_in <= 1'b1;
         repeat (5) @(posedge ref_clk);
         index_pulse_in <= 1'b0;
      end
      wait_irq();
      wb(1'b0, ADDR_RESULT, 32'h0, 4'hf, r);
      chk("no_mark", {1'b1, IC_ABNORMAL}, {r[16], r[7:6]});
      sense(r);
      cmd(OP_READ_ID, 2'h0, 8'h00);
      {id_valid_in, id_f} <= {1'b1, 32'h07011202};
      @(posedge ref_clk);
      id_f <= 32'h09000101;
      @(posedge ref_clk);
      id_valid_in <= 1'b0;
      wait_irq();
      wb(1'b0, ADDR_IDFIELD, 32'h0, 4'hf, r);
      chk("id_first", 32'h07011202, r);
      sense(r);
      $display("test read id done");
      xfer <= 1'b1;
      @(posedge ref_clk);
      xfer <= 1'b0;
      wait_irq();
      sense(r);
      chk("xfer_clear", 0, irq);
      wb(1'b1, ADDR_CONFIG, 32'h2, 4'h1, r);
      breq <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("byte_irq", 1, irq);
      breq <= 1'b0;
      cmd(OP_OTHER, 2'h0, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk("other_quiet", 0, irq);
      wb(1'b0, 8'h20, 32'h0, 4'hf, r);
      chk("unmapped", 0, r);
      cmd(OP_SEEK, 2'h0, 8'h09);
      wait_irq();
      wb(1'b0, ADDR_STATUS, 32'h0, 4'hf, r);
      chk("unsensed_busy", 32'h2, r & 32'h3);
      cmd(OP_PWR_DOWN, 2'h0, 8'h00);
      cmd(OP_PWR_UP, 2'h0, 8'h00);
      wb(1'b0, ADDR_RESULT, 32'h0, 4'hf, r);
      chk("wake_irq", 0, irq);
      chk("wake_clear", 0, r);
      $display("test events and power done");
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("reset_irq", 0, irq);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("reset_poll", 1, irq);
      sense(r);
      chk("reset_cause", res(IC_POLL, 0, 0, 0, 0), r & 32'h100ff);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule : fhs_seek_ctrl_tb_top
